// ### verilog/pie_pkg.sv
// pie_pkg: constants, carriers and state layout of the interrupt block
// assumes one 125 MHz clock shared with the cpu, peripherals and bus
package pie_pkg;
   // source population
   localparam int NSRC = 28;
   localparam int NCH = 8;
   localparam int NEXT = 8;
   localparam int NPER = 13;
   localparam int NXN = 4;
   localparam int NSW = 3;
   // register map, byte offsets
   localparam logic [11:0] OFS_CTL = 12'h000;
   localparam logic [11:0] OFS_CH = 12'h100;
   localparam logic [1:0] CH_SRC = 2'h0;
   localparam logic [1:0] CH_DST = 2'h1;
   localparam logic [1:0] CH_CNT = 2'h2;
   localparam logic [11:0] OFS_EDGE = 12'h200;
   localparam logic [11:0] OFS_STAT = 12'h204;
   localparam logic [11:0] OFS_MASK = 12'h208;
   localparam logic [11:0] OFS_STATE = 12'h20C;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // edge select codes, two bits per fast input
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // response window
   localparam int CLK_NS = 8;
   localparam int RESP_MIN_NS = 250;
   localparam int RESP_MAX_NS = 600;
   localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_NS;
   // vector numbers per source, source 27 first; vector address is number times four
   localparam logic [NSRC-1:0][6:0] TRAP_NUM = {
      7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h40,
      7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2B, 7'h47, 7'h2A, 7'h27, 7'h26, 7'h25, 7'h24, 7'h23, 7'h22,
      7'h1F, 7'h1E, 7'h1D, 7'h1C, 7'h1B, 7'h1A, 7'h19, 7'h18};

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACC = 3'b010,
      BUS_RESP = 3'b100
   } pie_bus_t;

   // per-source control word: [3:0] level, [4] enable, [5] request, [6] route, [9:7] channel
   typedef struct packed {
      logic [2:0] ch;
      logic route;
      logic ir;
      logic ie;
      logic [3:0] lvl;
   } pie_ctl_t;

   typedef struct packed {
      logic cont;
      logic incdst;
      logic word;
   } pie_mode_t;

   typedef struct packed {
      logic req;
      logic [3:0] lvl;
      logic [4:0] src;
      logic [15:0] vec;
   } pie_irq_t;

   typedef struct packed {
      logic valid;
      logic word;
      logic [2:0] ch;
      logic [15:0] src;
      logic [15:0] dst;
   } pie_xfer_t;

   typedef struct packed {
      logic valid;
      logic [15:0] vec;
   } pie_trap_t;

   typedef struct packed {
      pie_bus_t bus;
      logic [11:0] waddr;
      logic wr;
      logic wok;
      logic hready;
      logic [31:0] hrdata;
      pie_ctl_t [NSRC-1:0] ctl;
      logic [NCH-1:0][15:0] sptr;
      logic [NCH-1:0][15:0] dptr;
      logic [NCH-1:0][7:0] cnt;
      pie_mode_t [NCH-1:0] mode;
      logic [15:0] edge_cfg;
      logic [7:0] status;
      logic [7:0] mask;
      logic [NEXT-1:0] ext_s1;
      logic [NEXT-1:0] ext_s2;
      logic [NEXT-1:0] ext_prev;
      pie_irq_t irq;
      pie_xfer_t xfer;
      pie_trap_t trap;
      logic irq_out;
   } pie_state_t;

   localparam pie_state_t ST_RST = '{bus: BUS_IDLE, hready: 1'b1, default: '0};
endpackage

// ### verilog/pie_ctrl.sv
// pie_ctrl: prioritised interrupt controller with eight event-transfer channels
// assumes an ahb-lite master on hclk, peripheral requests on hclk, fast pins asynchronous
`timescale 1ns/100ps
module pie_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [pie_pkg::NEXT-1:0] ext_pin,
   input wire logic [pie_pkg::NPER-1:0] per_req,
   input wire logic [pie_pkg::NXN-1:0] xn_req,
   input wire logic [3:0] cpu_ilvl,
   input wire logic cpu_ack,
   input wire logic trap_valid,
   input wire logic [6:0] trap_num,
   output pie_pkg::pie_irq_t irq,
   output pie_pkg::pie_xfer_t xfer,
   output pie_pkg::pie_trap_t trap,
   output logic irq_out
);
   pie_pkg::pie_state_t st;
   pie_pkg::pie_state_t next_st;
   logic found;
   logic [4:0] widx;
   logic [3:0] wlvl;
   logic [2:0] wch;
   logic ev_go;
   logic win_std;
   logic ack_now;
   logic take;
   logic wr_go;
   logic is_ctl;
   logic is_ch;
   logic [11:0] a;
   logic [4:0] sidx;
   logic [2:0] cidx;
   logic [1:0] csel;
   logic [31:0] rdata;
   logic [7:0] stat_clr;
   logic [7:0] done_set;
   logic [pie_pkg::NEXT-1:0] edge_hit;
   logic [pie_pkg::NSRC-1:0] hw_set;
   logic [15:0] step;

   // outputs straight from the state register; hresp is tied low
   assign hreadyout = st.hready;
   assign hresp = 1'b0;
   assign hrdata = st.hrdata;
   assign irq = st.irq;
   assign xfer = st.xfer;
   assign trap = st.trap;
   assign irq_out = st.irq_out;

   // next-state logic of the whole block
   always_comb begin
      next_st = st;
      found = 1'b0;
      widx = 5'h00;
      wlvl = 4'h0;
      rdata = 32'h0000_0000;
      stat_clr = 8'h00;
      done_set = 8'h00;
      step = 16'h0001;
      a = st.waddr;
      sidx = a[6:2];
      cidx = a[6:4];
      csel = a[3:2];

      // highest level wins, lower index on a tie
      // must exceed the running service level
      for (int i = 0; i < pie_pkg::NSRC; i++) begin
         if (st.ctl[i].ir && st.ctl[i].ie && st.ctl[i].lvl > cpu_ilvl &&
             (!found || st.ctl[i].lvl > wlvl)) begin
            found = 1'b1;
            widx = 5'(i);
            wlvl = st.ctl[i].lvl;
         end
      end
      wch = st.ctl[widx].ch;
      // exhausted channel falls back to the vector
      ev_go = found && st.ctl[widx].route && (st.cnt[wch] != 8'h00 || st.mode[wch].cont);
      win_std = found && !ev_go;
      ack_now = cpu_ack && st.irq.req;

      // fast inputs: two-flop synchroniser then edge history
      next_st.ext_s1 = ext_pin;
      next_st.ext_s2 = st.ext_s1;
      next_st.ext_prev = st.ext_s2;
      for (int k = 0; k < pie_pkg::NEXT; k++) begin
         edge_hit[k] = (st.ext_s2[k] && !st.ext_prev[k] && st.edge_cfg[2*k]) ||
                       (!st.ext_s2[k] && st.ext_prev[k] && st.edge_cfg[2*k+1]);
      end
      // software nodes have no hardware request
      hw_set = {{pie_pkg::NSW{1'b0}}, xn_req, per_req, edge_hit};

      // register decode
      is_ctl = a[11:7] == pie_pkg::OFS_CTL[11:7] && sidx < 5'(pie_pkg::NSRC) && a[1:0] == 2'h0;
      is_ch = a[11:7] == pie_pkg::OFS_CH[11:7] && a[1:0] == 2'h0 && csel != 2'h3;
      take = hsel && htrans[1] && hready;
      wr_go = st.bus == pie_pkg::BUS_ACC && st.wr && st.wok;

      // read mux
      if (is_ctl) begin
         rdata = {22'h00_0000, st.ctl[sidx]};
      end else if (is_ch) begin
         case (csel)
            pie_pkg::CH_SRC: rdata = {16'h0000, st.sptr[cidx]};
            pie_pkg::CH_DST: rdata = {16'h0000, st.dptr[cidx]};
            default: rdata = {21'h00_0000, st.mode[cidx], st.cnt[cidx]};
         endcase
      end else begin
         case (a)
            pie_pkg::OFS_EDGE: rdata = {16'h0000, st.edge_cfg};
            pie_pkg::OFS_STAT: rdata = {24'h00_0000, st.status};
            pie_pkg::OFS_MASK: rdata = {24'h00_0000, st.mask};
            pie_pkg::OFS_STATE: rdata = {18'h0_0000, st.irq.req, st.irq.lvl, st.irq.src, 4'h0};
            default: rdata = 32'h0000_0000;
         endcase
      end

      // register writes, applied in the data phase
      if (wr_go) begin
         // request, enable and level per source
         if (is_ctl) begin
            next_st.ctl[sidx] = pie_pkg::pie_ctl_t'(hwdata[9:0]);
         end else if (is_ch) begin
            case (csel)
               pie_pkg::CH_SRC: next_st.sptr[cidx] = hwdata[15:0];
               pie_pkg::CH_DST: next_st.dptr[cidx] = hwdata[15:0];
               default: begin
                  next_st.cnt[cidx] = hwdata[7:0];
                  next_st.mode[cidx] = pie_pkg::pie_mode_t'(hwdata[10:8]);
               end
            endcase
         end else begin
            case (a)
               pie_pkg::OFS_EDGE: next_st.edge_cfg = hwdata[15:0];
               pie_pkg::OFS_STAT: stat_clr = hwdata[7:0];
               pie_pkg::OFS_MASK: next_st.mask = hwdata[7:0];
               default: next_st.mask = st.mask;
            endcase
         end
      end

      // ahb-lite slave: one wait state on every transfer
      case (st.bus)
         pie_pkg::BUS_IDLE, pie_pkg::BUS_RESP: begin
            if (take) begin
               next_st.bus = pie_pkg::BUS_ACC;
               next_st.waddr = haddr[11:0];
               next_st.wr = hwrite;
               next_st.wok = hsize == pie_pkg::HSIZE_WORD;
               next_st.hready = 1'b0;
            end else begin
               next_st.bus = pie_pkg::BUS_IDLE;
               next_st.hready = 1'b1;
            end
         end
         pie_pkg::BUS_ACC: begin
            next_st.bus = pie_pkg::BUS_RESP;
            next_st.hready = 1'b1;
            next_st.hrdata = st.wr ? 32'h0000_0000 : rdata;
         end
         default: begin
            next_st.bus = pie_pkg::BUS_IDLE;
            next_st.hready = 1'b1;
         end
      endcase

      if (ack_now) begin
         next_st.ctl[st.irq.src].ir = 1'b0;
      end

      // eight channels, one served per cycle
      // a single one-cycle move, no branch
      next_st.xfer.valid = ev_go;
      if (ev_go) begin
         next_st.ctl[widx].ir = 1'b0;
         next_st.xfer.word = st.mode[wch].word;
         next_st.xfer.ch = wch;
         next_st.xfer.src = st.sptr[wch];
         next_st.xfer.dst = st.dptr[wch];
         // bump one pointer by the item size
         step = st.mode[wch].word ? 16'h0002 : 16'h0001;
         if (st.mode[wch].incdst) begin
            next_st.dptr[wch] = 16'(st.dptr[wch] + step);
         end else begin
            next_st.sptr[wch] = 16'(st.sptr[wch] + step);
         end
         if (!st.mode[wch].cont) begin
            next_st.cnt[wch] = 8'(st.cnt[wch] - 8'h01);
            done_set[wch] = st.cnt[wch] == 8'h01;
         end
      end

      // present winner to the cpu, gap after accept
      // request shows on the next edge
      next_st.irq.req = win_std && !ack_now;
      if (win_std) begin
         next_st.irq.lvl = wlvl;
         next_st.irq.src = widx;
         // vector from the source's own number
         next_st.irq.vec = {7'h00, pie_pkg::TRAP_NUM[widx], 2'b00};
      end

      // hardware requests land last so a set beats a clear
      for (int j = 0; j < pie_pkg::NSRC; j++) begin
         if (hw_set[j]) begin
            next_st.ctl[j].ir = 1'b1;
         end
      end
      next_st.status = (st.status & ~stat_clr) | done_set;
      next_st.irq_out = |(next_st.status & next_st.mask);

      // software trap number to vector address
      next_st.trap.valid = trap_valid;
      if (trap_valid) begin
         next_st.trap.vec = {7'h00, trap_num, 2'b00};
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= pie_pkg::ST_RST;
      end else begin
         st <= next_st;
      end
   end

   // helper for checks: channel figures seen when a move was launched
   logic [7:0] chk_cnt;
   logic chk_cont;
   logic chk_wr;
   localparam int resp_max = pie_pkg::RESP_MAX_CYC;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_cnt <= 8'h00;
         chk_cont <= 1'b0;
         chk_wr <= 1'b0;
      end else begin
         chk_cnt <= st.cnt[wch];
         chk_cont <= st.mode[wch].cont;
         chk_wr <= wr_go;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // checks on the channel counter
   chk_cnt_step: assert property (xfer.valid && !chk_cont && !chk_wr |-> st.cnt[xfer.ch] == 8'(chk_cnt - 8'h01))
      else $error("channel counter did not step down by one");
   chk_cnt_hold: assert property (xfer.valid && chk_cont && !chk_wr |-> st.cnt[xfer.ch] == chk_cnt)
      else $error("continuous channel counter changed");
   chk_zero_std: assert property (xfer.valid |-> chk_cnt != 8'h00 || chk_cont)
      else $error("move issued on an exhausted channel");
   chk_done_flag: assert property (xfer.valid && !chk_cont && chk_cnt == 8'h01 |-> st.status[xfer.ch])
      else $error("channel done flag missing");

   // checks on the cpu request
   chk_level_above: assert property (irq.req |-> irq.lvl > $past(cpu_ilvl))
      else $error("request not above running level");
   chk_ack_drop: assert property (irq.req && cpu_ack |=> !irq.req)
      else $error("request stayed up after accept");
   chk_vec_src: assert property (irq.req |-> irq.vec == {7'h00, pie_pkg::TRAP_NUM[irq.src], 2'b00})
      else $error("vector does not match source");
   chk_resp_time: assert property (win_std && !cpu_ack |-> ##[1:resp_max] irq.req)
      else $error("request later than response window");

   // edge and trap checks
   chk_edge_rise: assert property (st.edge_cfg[0] && st.ext_s2[0] && !st.ext_prev[0] |=> st.ctl[0].ir)
      else $error("rising edge lost on fast input 0");
   chk_trap_vec: assert property (trap_valid |=> trap.valid && trap.vec == {7'h00, $past(trap_num), 2'b00})
      else $error("trap vector wrong");

   // main scenarios
   cov_move: cover property (xfer.valid);
   cov_burst: cover property (xfer.valid ##1 xfer.valid);
   cov_accept: cover property (irq.req && cpu_ack);
   cov_trap: cover property (trap.valid);
endmodule // pie_ctrl

// ### dv/pie_src_model.sv
// pie_src_model: peripherals, expansion nodes and fast pins raising requests
// assumes the bench names sources by a kick mask on hclk
`timescale 1ns/100ps
module pie_src_model (
   input wire logic hclk,
   input wire logic [27:0] kick,
   input wire logic [7:0] pin_lvl,
   output logic [pie_pkg::NPER-1:0] per_req,
   output logic [pie_pkg::NXN-1:0] xn_req,
   output logic [pie_pkg::NEXT-1:0] ext_pin
);
   // quiet lines before the first edge
   initial begin
      per_req = '0;
      xn_req = '0;
      ext_pin = '0;
   end
   // one-cycle requests
   // each kicked peripheral or expansion source pulses for one cycle; pins follow the bench level
   always @(posedge hclk) begin
      per_req <= kick[20:8];
      xn_req <= kick[24:21];
      ext_pin <= pin_lvl;
   end
endmodule // pie_src_model

// ### dv/pie_ctrl_tb.sv
// pie_ctrl_tb: bus-driven tests of the interrupt block
// assumes pie_ctrl alone on the bus and the source model beside it
`timescale 1ns/100ps
module pie_ctrl_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = '0;
   logic [31:0] hwdata = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [27:0] kick = '0;
   logic [7:0] pin_lvl = '0;
   logic [12:0] per_req;
   logic [3:0] xn_req;
   logic [7:0] ext_pin;
   logic [3:0] cpu_ilvl = '0;
   logic cpu_ack = 1'b0;
   logic trap_valid = 1'b0;
   logic [6:0] trap_num = '0;
   pie_pkg::pie_irq_t irq;
   pie_pkg::pie_xfer_t xfer;
   pie_pkg::pie_trap_t trap;
   logic irq_out;
   logic [31:0] q;
   int fail_count = 0;
   int total_checks = 0;
   // bench clock, 8 ns
   always #4 hclk = ~hclk;
   pie_src_model i_pie_src_model (.hclk(hclk), .kick(kick), .pin_lvl(pin_lvl), .per_req(per_req),
      .xn_req(xn_req), .ext_pin(ext_pin));
   pie_ctrl i_pie_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ext_pin(ext_pin), .per_req(per_req), .xn_req(xn_req),
      .cpu_ilvl(cpu_ilvl), .cpu_ack(cpu_ack), .trap_valid(trap_valid), .trap_num(trap_num),
      .irq(irq), .xfer(xfer), .trap(trap), .irq_out(irq_out));
   // compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // bounded wait: 0 for irq.req, 1 for xfer.valid, 2 for hreadyout
   task automatic wait_for(input int which);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (n < 20 && (which == 0 ? irq.req : which == 1 ? xfer.valid : hreadyout) !== 1'b1);
      // a wait that runs out counts as a mismatch
      if ((which == 0 ? irq.req : which == 1 ? xfer.valid : hreadyout) !== 1'b1) begin
         fail_count++;
         $display("MISMATCH wait %0d expected 1 seen timeout", which);
      end
   endtask
   // single ahb-lite word transfer, address then data phase
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= pie_pkg::HSIZE_WORD;
      wait_for(2);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_for(2);
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
      bus(1'b0, a, 32'h0);
      chk(what, e, q);
   endtask
   task automatic kick_src(input logic [27:0] m);
      @(posedge hclk);
      kick <= m;
      @(posedge hclk);
      kick <= '0;
   endtask
   // await a vector request, check it, accept it
   task automatic take(input logic [4:0] s, input logic [3:0] l, input logic [15:0] v);
      wait_for(0);
      chk("irq src", {27'h0, s}, {27'h0, irq.src});
      chk("irq lvl", {28'h0, l}, {28'h0, irq.lvl});
      chk("irq vec", {16'h0, v}, {16'h0, irq.vec});
      cpu_ack <= 1'b1;
      @(posedge hclk);
      cpu_ack <= 1'b0;
      @(posedge hclk);
      chk("irq drop", 32'h0, {31'h0, irq.req});
   endtask
   // await a channel move and check its addresses
   task automatic move(input logic [2:0] c, input logic [15:0] s, input logic [15:0] d, input logic w);
      wait_for(1);
      chk("xfer addr", {s, d}, {xfer.src, xfer.dst});
      chk("xfer kind", {28'h0, w, c}, {28'h0, xfer.word, xfer.ch});
      @(posedge hclk);
      chk("xfer one cycle", 32'h0, {31'h0, xfer.valid});
   endtask
   task automatic pin_step(input logic v, input logic e);
      pin_lvl <= {7'h0, v};
      idle(6);
      chk("pin edge", {31'h0, e}, {31'h0, irq.req});
      if (e) take(5'h0, 4'h1, 16'h0060);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rd(12'h000, 32'h0, "ctl reset");
      rd(12'h300, 32'h0, "unmapped");
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("irq_out reset", 32'h0, {31'h0, irq_out});
      $display("test reset done");
      // levels, preemption and arbitration
      wr(12'h028, 32'h16);
      wr(12'h02C, 32'h19);
      cpu_ilvl <= 4'h9;
      kick_src(28'h000_0C00);
      idle(6);
      chk("no preempt", 32'h0, {31'h0, irq.req});
      cpu_ilvl <= 4'h8;
      take(5'hB, 4'h9, 16'h0094);
      rd(12'h02C, 32'h19, "flag cleared");
      cpu_ilvl <= 4'h0;
      take(5'hA, 4'h6, 16'h0090);
      $display("test priority done");
      // counted channel moves then vector
      wr(12'h024, 32'h53);
      wr(12'h100, 32'h1000);
      wr(12'h104, 32'h2000);
      wr(12'h108, 32'h302);
      wr(12'h208, 32'h1);
      for (int k = 0; k < 2; k++) begin
         kick_src(28'h000_0200);
         move(3'h0, 16'h1000, 16'h2000 + 16'(2 * k), 1'b1);
      end
      rd(12'h108, 32'h300, "count zero");
      chk("irq_out done", 32'h1, {31'h0, irq_out});
      kick_src(28'h000_0200);
      take(5'h9, 4'h3, 16'h008C);
      wr(12'h204, 32'h1);
      idle(2);
      chk("irq_out clear", 32'h0, {31'h0, irq_out});
      rd(12'h204, 32'h0, "status clear");
      // continuous byte moves on the last channel
      wr(12'h024, 32'h3D3);
      wr(12'h170, 32'h1000);
      wr(12'h178, 32'h400);
      kick_src(28'h000_0200);
      move(3'h7, 16'h1000, 16'h0000, 1'b0);
      rd(12'h178, 32'h400, "count kept");
      rd(12'h170, 32'h1001, "src bumped");
      $display("test channels done");
      // fast pin edge codes
      wr(12'h000, 32'h11);
      for (int c = 1; c < 4; c++) begin
         wr(12'h200, 32'(c));
         pin_step(1'b1, c[0]);
         pin_step(1'b0, c[1]);
      end
      $display("test pins done");
      // expansion and software nodes
      wr(12'h054, 32'h14);
      kick_src(28'h020_0000);
      take(5'h15, 4'h4, 16'h0100);
      wr(12'h058, 32'h34);
      take(5'h16, 4'h4, 16'h0104);
      wr(12'h064, 32'h37);
      rd(12'h20C, 32'h2F90, "irq state");
      take(5'h19, 4'h7, 16'h0110);
      rd(12'h064, 32'h17, "sw flag cleared");
      $display("test nodes done");
      // software trap number to vector
      trap_num <= 7'h2A;
      trap_valid <= 1'b1;
      @(posedge hclk);
      trap_valid <= 1'b0;
      @(posedge hclk);
      chk("trap", {15'h0, 1'b1, 16'h00A8}, {15'h0, trap.valid, trap.vec});
      $display("test trap done");
      close_out();
   end
endmodule // pie_ctrl_tb
